//--- bench/asg_far_model.sv
// far-side model: general register file and data memory with wait states
`timescale 1ns/1ns
module asg_far_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register file
    input wire logic [7:0] rfa_addr_i,
    input wire logic [7:0] rfb_addr_i,
    output logic [15:0] rfa_data_o,
    output logic [15:0] rfb_data_o,
    input wire logic rf_we_i,
    input wire asg_pkg::asg_rf_wr_t rf_wr_i,
    // data memory
    input wire logic mem_req_i,
    input wire asg_pkg::asg_mem_t mem_i,
    output logic [15:0] mem_rdata_o,
    output logic mem_ack_o
);
    import asg_pkg::*;
    logic [15:0] rf [16];
    logic [7:0] mem [256];
    int wait_n = 0;
    int cnt;
    logic [15:0] last = 16'h0000;
    logic [7:0] a;
    assign a = mem_i.addr[7:0];
    assign rfa_data_o = rf[rfa_addr_i[3:0]];
    assign rfb_data_o = rf[rfb_addr_i[3:0]];
    assign mem_ack_o = mem_req_i && (cnt == wait_n);
    // idle bus shows the inverse of the last value so stale data cannot pass
    always_comb begin
        mem_rdata_o = ~last;
        if (mem_ack_o && !mem_i.we) begin
            mem_rdata_o = {mem[a + 8'h01], mem[a]};
            if (mem_i.byte_op) begin
                mem_rdata_o[15:8] = ~last[15:8];
            end
        end
    end
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 0;
        end else begin
            cnt <= (mem_req_i && !mem_ack_o) ? cnt + 1 : 0;
            if (mem_ack_o) begin
                last <= mem_rdata_o;
                if (mem_i.we) begin
                    mem[a] <= mem_i.wdata[7:0];
                    if (!mem_i.byte_op) begin
                        mem[a + 8'h01] <= mem_i.wdata[15:8];
                    end
                end
            end
            // byte writes touch only the enabled lane
            if (rf_we_i && rf_wr_i.addr[7:4] == 4'hf) begin
                if (rf_wr_i.be[0]) rf[rf_wr_i.addr[3:0]][7:0] <= rf_wr_i.data[7:0];
                if (rf_wr_i.be[1]) rf[rf_wr_i.addr[3:0]][15:8] <= rf_wr_i.data[15:8];
            end
        end
    end
endmodule

//--- bench/testbench.sv
// self-checking bench for the add/subtract group execute block
`timescale 1ns/1ns
module testbench;
    import asg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic instr_valid_i = 1'b0;
    asg_instr_t instr_i = '0;
    logic instr_ready_o, done_o, illegal_o, rf_we_o, mem_req_o, mem_ack_i;
    logic [2:0] length_o;
    logic [7:0] rfa_addr_o, rfb_addr_o;
    logic [15:0] rfa_data_i, rfb_data_i, mem_rdata_i;
    asg_rf_wr_t rf_wr_o;
    asg_mem_t mem_o;
    asg_flags_t flags_o;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #50 clk_i = ~clk_i;
    asg_exec uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .instr_ready_o(instr_ready_o), .done_o(done_o),
        .length_o(length_o), .illegal_o(illegal_o), .rfa_addr_o(rfa_addr_o),
        .rfa_data_i(rfa_data_i), .rfb_addr_o(rfb_addr_o), .rfb_data_i(rfb_data_i),
        .rf_we_o(rf_we_o), .rf_wr_o(rf_wr_o), .mem_req_o(mem_req_o), .mem_o(mem_o),
        .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .flags_o(flags_o));
    asg_far_model far (.clk_i(clk_i), .rst_b_i(rst_b_i), .rfa_addr_i(rfa_addr_o),
        .rfb_addr_i(rfb_addr_o), .rfa_data_o(rfa_data_i), .rfb_data_o(rfb_data_i),
        .rf_we_i(rf_we_o), .rf_wr_i(rf_wr_o), .mem_req_i(mem_req_o), .mem_i(mem_o),
        .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // op is {sub, carry, byte}
    function automatic asg_instr_t mk(input logic [2:0] op, input asg_form_t f,
            input logic lane, input logic [7:0] fld, input logic [15:0] ext);
        mk = {op, f, 1'b0, lane, fld, ext};
    endfunction
    // offer one instruction, wait for done under a bound, check its length
    task automatic exec(input asg_instr_t ins, input logic [2:0] len);
        int n;
        @(negedge clk_i);
        instr_i = ins;
        instr_valid_i = 1'b1;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk4("done", 4'h1, {3'h0, done_o});
        chk4("length", {1'b0, len}, {1'b0, length_o});
    endtask
    task automatic t_carry_chain();
        far.rf[1] = 16'hffff;
        far.rf[2] = 16'h0001;
        exec(mk(3'b000, F_RR, 1'b0, 8'h12, 16'h0000), LEN_SHORT);
        chk16("r1", 16'h0000, far.rf[1]);
        chk4("flags", 4'b1001, flags_o);
        far.rf[3] = 16'h0010;
        far.rf[4] = 16'h0001;
        exec(mk(3'b010, F_RR, 1'b0, 8'h34, 16'h0000), LEN_SHORT);
        chk16("r3", 16'h0012, far.rf[3]);
        far.rf[5] = 16'h0000;
        far.rf[6] = 16'h0001;
        exec(mk(3'b100, F_RR, 1'b0, 8'h56, 16'h0000), LEN_SHORT);
        chk16("r5", 16'hffff, far.rf[5]);
        chk4("flags", 4'b0101, flags_o);
        far.rf[7] = 16'h0010;
        exec(mk(3'b110, F_IMM3, 1'b0, 8'h72, 16'h0000), LEN_SHORT);
        chk16("r7", 16'h000d, far.rf[7]);
    endtask
    task automatic t_byte_rr();
        far.rf[1] = 16'haa7f;
        far.rf[2] = 16'h0180;
        exec(mk(3'b001, F_RR, 1'b0, 8'h25, 16'h0000), LEN_SHORT);
        chk16("r1", 16'haa80, far.rf[1]);
        chk4("flags", 4'b0110, flags_o);
    endtask
    task automatic t_postinc();
        far.wait_n = 2;
        far.rf[3] = 16'h0005;
        far.rf[4] = 16'h0040;
        far.mem[8'h40] = 8'h00;
        far.mem[8'h41] = 8'h01;
        far.mem[8'h42] = 8'h03;
        exec(mk(3'b000, F_INC, 1'b0, 8'h34, 16'h0000), LEN_SHORT);
        chk16("r3", 16'h0105, far.rf[3]);
        chk16("ptr", 16'h0042, far.rf[4]);
        exec(mk(3'b001, F_INC, 1'b0, 8'h64, 16'h0000), LEN_SHORT);
        chk16("r3", 16'h0108, far.rf[3]);
        chk16("ptr", 16'h0043, far.rf[4]);
        far.rf[1] = 16'h0000;
        far.rf[4] = 16'h0040;
        exec(mk(3'b100, F_IND, 1'b0, 8'h14, 16'h0000), LEN_SHORT);
        chk16("r1", 16'hff00, far.rf[1]);
        exec(mk(3'b111, F_IND, 1'b0, 8'h24, 16'h0000), LEN_SHORT);
        chk16("r1", 16'hffff, far.rf[1]);
        chk16("ptr", 16'h0040, far.rf[4]);
        chk4("flags", 4'b0101, flags_o);
    endtask
    task automatic t_long();
        far.wait_n = 0;
        far.rf[5] = 16'hffff;
        exec(mk(3'b000, F_RIMM, 1'b0, 8'hf5, 16'h1000), LEN_LONG);
        chk16("r5", 16'h0fff, far.rf[5]);
        exec(mk(3'b001, F_RIMM, 1'b1, 8'hf5, 16'h00ff), LEN_LONG);
        chk16("r5", 16'h0eff, far.rf[5]);
        far.rf[6] = 16'h0003;
        far.mem[8'h80] = 8'h05;
        exec(mk(3'b101, F_RMEM, 1'b0, 8'hf6, 16'h0080), LEN_LONG);
        chk16("r6", 16'h00fe, far.rf[6]);
        far.wait_n = 1;
        far.rf[7] = 16'h2222;
        far.mem[8'h90] = 8'h11;
        far.mem[8'h91] = 8'h11;
        exec(mk(3'b000, F_MREG, 1'b0, 8'hf7, 16'h0090), LEN_LONG);
        chk16("mem90", 16'h3333, {far.mem[8'h91], far.mem[8'h90]});
    endtask
    // an unused form code is refused, ready stays high and no done
    task automatic t_illegal();
        @(negedge clk_i);
        instr_i = mk(3'b000, asg_form_t'(3'h7), 1'b0, 8'h12, 16'h0000);
        instr_valid_i = 1'b1;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        chk4("illegal", 4'h1, {3'h0, illegal_o});
        chk4("ready", 4'h1, {3'h0, instr_ready_o});
        chk4("done", 4'h0, {3'h0, done_o});
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge clk_i);
        rst_b_i = 1'b1;
        t_carry_chain();
        t_byte_rr();
        t_postinc();
        t_long();
        t_illegal();
        give_verdict();
    end
endmodule

//--- core/asg_exec.sv
// add/subtract group decode and execute engine
`timescale 1ns/1ns
module asg_exec (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // instruction stream
    input wire logic instr_valid_i,
    input wire asg_pkg::asg_instr_t instr_i,
    output logic instr_ready_o,
    output logic done_o,
    output logic [2:0] length_o,
    output logic illegal_o,
    // register file
    output logic [7:0] rfa_addr_o,
    input wire logic [15:0] rfa_data_i,
    output logic [7:0] rfb_addr_o,
    input wire logic [15:0] rfb_data_i,
    output logic rf_we_o,
    output asg_pkg::asg_rf_wr_t rf_wr_o,
    // data memory
    output logic mem_req_o,
    output asg_pkg::asg_mem_t mem_o,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_ack_i,
    // status flags
    output asg_pkg::asg_flags_t flags_o
);
    import asg_pkg::*;

    asg_state_t state, next_state;
    asg_instr_t ins, next_ins;
    logic [15:0] op_a, next_op_a, op_b, next_op_b, ptr, next_ptr;
    asg_rf_wr_t rf_wr, next_rf_wr;
    asg_mem_t mem, next_mem;
    asg_flags_t flags, next_flags, alu_flags;
    logic done, next_done, illegal, next_illegal;
    logic [2:0] len, next_len;
    logic [16:0] sum;
    logic [15:0] res, step;
    logic msb_a, msb_b, msb_r, cin, dst_lane;
    logic [7:0] dst_addr;
    logic [1:0] dst_be;

    function automatic logic [7:0] gpr_addr(input logic [3:0] num, input logic byte_sel);
        gpr_addr = byte_sel ? (GPR_BASE | {5'h00, num[3:1]}) : (GPR_BASE | {4'h0, num});
    endfunction

    function automatic logic [15:0] pick(input logic [15:0] w, input logic byte_sel,
                                         input logic hi);
        pick = !byte_sel ? w : (hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]});
    endfunction

    function automatic logic long_form(input asg_form_t f);
        long_form = f inside {F_RIMM, F_RMEM, F_MREG};
    endfunction

    function automatic logic mem_src(input asg_form_t f);
        mem_src = f inside {F_IND, F_INC, F_RMEM, F_MREG};
    endfunction

    // operand addressing
    assign dst_addr = long_form(ins.form) ? ins.field : gpr_addr(ins.field[7:4], ins.byte_op);
    assign dst_lane = long_form(ins.form) ? ins.lane : ins.field[4];
    // byte writes touch one lane only, the other byte stays as it was
    assign dst_be = !ins.byte_op ? BE_WORD : (dst_lane ? BE_HI : BE_LO);
    // pointer is always a word register, even for byte ops
    assign rfb_addr_o = gpr_addr(ins.field[3:0], ins.byte_op && ins.form == F_RR);
    assign rfa_addr_o = dst_addr;
    assign step = ins.byte_op ? PTR_STEP_BYTE : PTR_STEP_WORD;

    // arithmetic: op_a is always the destination, op_b the source
    assign cin = ins.carry_op & flags.c;
    assign sum = ins.sub_op ? ({1'b0, op_a} - {1'b0, op_b} - {16'h0000, cin})
                            : ({1'b0, op_a} + {1'b0, op_b} + {16'h0000, cin});
    assign res = ins.byte_op ? {sum[7:0], sum[7:0]} : sum[15:0];
    assign msb_a = ins.byte_op ? op_a[7] : op_a[15];
    assign msb_b = ins.byte_op ? op_b[7] : op_b[15];
    assign msb_r = ins.byte_op ? sum[7] : sum[15];
    // flags at operand width; carry is borrow for subtracts
    assign alu_flags.z = ins.byte_op ? (sum[7:0] == 8'h00) : (sum[15:0] == 16'h0000);
    assign alu_flags.n = msb_r;
    assign alu_flags.c = ins.byte_op ? sum[8] : sum[16];
    assign alu_flags.v = (ins.sub_op ? (msb_a != msb_b) : (msb_a == msb_b)) && (msb_r != msb_a);

    always_comb begin
        next_state = state;
        next_ins = ins;
        next_op_a = op_a;
        next_op_b = op_b;
        next_ptr = ptr;
        next_rf_wr = rf_wr;
        next_mem = mem;
        next_flags = flags;
        next_done = 1'b0;
        next_illegal = 1'b0;
        next_len = len;
        unique case (state)
            S_IDLE: begin
                if (instr_valid_i) begin
                    if (instr_i.form inside {F_RR, F_IND, F_INC, F_IMM3, F_RIMM, F_RMEM, F_MREG})
                    begin
                        next_ins = instr_i;
                        next_state = S_OPER;
                    end else begin
                        next_illegal = 1'b1;
                    end
                end
            end
            S_OPER: begin
                next_op_a = pick(rfa_data_i, ins.byte_op, dst_lane);
                next_ptr = rfb_data_i;
                case (ins.form)
                    F_RR: next_op_b = pick(rfb_data_i, ins.byte_op, ins.field[0]);
                    F_IMM3: next_op_b = {13'h0000, ins.field[2:0]};
                    F_RIMM: next_op_b = pick(ins.ext, ins.byte_op, 1'b0);
                    default: next_op_b = op_b;
                endcase
                if (mem_src(ins.form)) begin
                    next_mem.we = 1'b0;
                    next_mem.byte_op = ins.byte_op;
                    next_mem.addr = (ins.form inside {F_IND, F_INC}) ? rfb_data_i : ins.ext;
                    next_state = S_MRD;
                end else begin
                    next_state = S_CALC;
                end
            end
            S_MRD: begin
                if (mem_ack_i) begin
                    if (ins.form == F_MREG) begin
                        // memory is the destination here, the register moves to the source side
                        next_op_b = op_a;
                        next_op_a = pick(mem_rdata_i, ins.byte_op, 1'b0);
                    end else begin
                        next_op_b = pick(mem_rdata_i, ins.byte_op, 1'b0);
                    end
                    next_state = S_CALC;
                end
            end
            S_CALC: begin
                next_flags = alu_flags;
                if (ins.form == F_MREG) begin
                    next_mem.we = 1'b1;
                    next_mem.wdata = res;
                end else begin
                    next_rf_wr.addr = dst_addr;
                    next_rf_wr.data = res;
                    next_rf_wr.be = dst_be;
                end
                next_state = S_WB;
            end
            S_WB: begin
                if (ins.form == F_MREG) begin
                    if (mem_ack_i) begin
                        next_done = 1'b1;
                        next_len = LEN_LONG;
                        next_state = S_IDLE;
                    end
                end else if (ins.form == F_INC) begin
                    // pointer written after the result, so it wins if both name one register
                    next_rf_wr.addr = rfb_addr_o;
                    next_rf_wr.data = ptr + step;
                    next_rf_wr.be = BE_WORD;
                    next_state = S_PINC;
                end else begin
                    next_done = 1'b1;
                    next_len = long_form(ins.form) ? LEN_LONG : LEN_SHORT;
                    next_state = S_IDLE;
                end
            end
            S_PINC: begin
                next_done = 1'b1;
                next_len = LEN_SHORT;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= S_IDLE;
            ins <= '0;
            op_a <= 16'h0000;
            op_b <= 16'h0000;
            ptr <= 16'h0000;
            rf_wr <= '0;
            mem <= '0;
            flags <= '0;
            done <= 1'b0;
            illegal <= 1'b0;
            len <= 3'h0;
        end else begin
            state <= next_state;
            ins <= next_ins;
            op_a <= next_op_a;
            op_b <= next_op_b;
            ptr <= next_ptr;
            rf_wr <= next_rf_wr;
            mem <= next_mem;
            flags <= next_flags;
            done <= next_done;
            illegal <= next_illegal;
            len <= next_len;
        end
    end

    assign instr_ready_o = state == S_IDLE;
    assign done_o = done;
    assign length_o = len;
    assign illegal_o = illegal;
    assign rf_we_o = (state == S_WB && ins.form != F_MREG) || state == S_PINC;
    assign rf_wr_o = rf_wr;
    assign mem_req_o = state == S_MRD || (state == S_WB && ins.form == F_MREG);
    assign mem_o = mem;
    assign flags_o = flags;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_mem_writeback;
        ##2 (mem_req_o && mem_o.we && mem_o.addr == ins.ext);
    endsequence

    sequence s_result_then_ptr;
        (state == S_WB && rf_we_o) ##1 (state == S_PINC && rf_we_o);
    endsequence

    a_ptr_word_step: assert property (
        state == S_PINC && !ins.byte_op |-> rf_wr_o.data == ptr + PTR_STEP_WORD)
        else $error("word pointer step is not two");
    a_ptr_byte_step: assert property (
        state == S_PINC && ins.byte_op |-> rf_wr_o.data == ptr + PTR_STEP_BYTE)
        else $error("byte pointer step is not one");
    a_ptr_after_result: assert property (
        state == S_CALC && ins.form == F_INC |=> s_result_then_ptr)
        else $error("pointer not written after result");
    a_short_length: assert property (
        done_o && ins.form inside {F_RR, F_IMM3, F_IND, F_INC} |-> length_o == LEN_SHORT)
        else $error("short form length wrong");
    a_long_length: assert property (
        done_o && long_form(ins.form) |-> length_o == LEN_LONG)
        else $error("long form length wrong");
    a_imm3_operand: assert property (
        state == S_CALC && ins.form == F_IMM3 |-> op_b == {13'h0000, ins.field[2:0]})
        else $error("short immediate operand wrong");
    a_byte_imm_operand: assert property (
        state == S_CALC && ins.form == F_RIMM && ins.byte_op |-> op_b == {8'h00, ins.ext[7:0]})
        else $error("byte immediate operand wrong");
    a_mem_dst_rmw: assert property (
        state == S_MRD && mem_ack_i && ins.form == F_MREG |-> s_mem_writeback)
        else $error("memory destination not written back");
    a_mem_src_read: assert property (
        state == S_MRD && ins.form == F_RMEM |-> !mem_o.we && mem_o.addr == ins.ext)
        else $error("direct memory source read wrong");
    a_add_carry_in: assert property (
        state == S_CALC && !ins.sub_op && ins.carry_op && !ins.byte_op && ins.form != F_MREG
        |=> rf_wr_o.data == 16'($past(op_a) + $past(op_b) + {15'h0000, $past(flags_o.c)}))
        else $error("carry add result wrong");
    a_sub_borrow_in: assert property (
        state == S_CALC && ins.sub_op && ins.carry_op && !ins.byte_op && ins.form != F_MREG
        |=> rf_wr_o.data == 16'($past(op_a) - $past(op_b) - {15'h0000, $past(flags_o.c)}))
        else $error("borrow subtract result wrong");
    a_byte_lane_keep: assert property (
        state == S_WB && rf_we_o && ins.byte_op |-> rf_wr_o.be != BE_WORD)
        else $error("byte write touches both lanes");
    a_ptr_word_reg: assert property (
        state == S_PINC |-> rf_wr_o.addr == (GPR_BASE | {4'h0, ins.field[3:0]}))
        else $error("pointer is not a word register");
    a_zero_flag: assert property (
        state == S_CALC && ins.form != F_MREG |=> flags_o.z ==
        (ins.byte_op ? rf_wr_o.data[7:0] == 8'h00 : rf_wr_o.data == 16'h0000))
        else $error("zero flag disagrees with result");

    // plain forms, negative flag, operand paths, bus width and bus hold
    a_add_plain: assert property (
        state == S_CALC && !ins.sub_op && !ins.carry_op && !ins.byte_op && ins.form != F_MREG
        |=> rf_wr_o.data == 16'($past(op_a) + $past(op_b)))
        else $error("plain add result wrong");
    a_sub_plain: assert property (
        state == S_CALC && ins.sub_op && !ins.carry_op && !ins.byte_op && ins.form != F_MREG
        |=> rf_wr_o.data == 16'($past(op_a) - $past(op_b)))
        else $error("plain subtract result wrong");
    a_neg_flag: assert property (
        state == S_CALC && ins.form != F_MREG |=> flags_o.n ==
        (ins.byte_op ? rf_wr_o.data[7] : rf_wr_o.data[15]))
        else $error("negative flag disagrees with result");
    a_mem_byte_access: assert property (
        mem_req_o |-> mem_o.byte_op == ins.byte_op)
        else $error("memory access width wrong");
    a_mem_req_hold: assert property (
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_o))
        else $error("memory request dropped before ack");
    a_long_word_imm: assert property (
        state == S_CALC && ins.form == F_RIMM && !ins.byte_op |-> op_b == ins.ext)
        else $error("long word immediate operand wrong");
    a_rr_operands: assert property (
        state == S_OPER && ins.form == F_RR && !ins.byte_op |=> op_b == $past(rfb_data_i))
        else $error("register source operand wrong");
    a_ind_ptr_addr: assert property (
        state == S_OPER && ins.form inside {F_IND, F_INC} |-> rfb_addr_o == (GPR_BASE | {4'h0, ins.field[3:0]}))
        else $error("indirect pointer is not a word register");
endmodule

//--- core/asg_pkg.sv
// constants and carrier types for the add/subtract group execute block
package asg_pkg;
    localparam logic [7:0] GPR_BASE = 8'hf0;
    localparam logic [15:0] PTR_STEP_WORD = 16'h0002;
    localparam logic [15:0] PTR_STEP_BYTE = 16'h0001;
    localparam logic [2:0] LEN_SHORT = 3'h2;
    localparam logic [2:0] LEN_LONG = 3'h4;
    localparam logic [1:0] BE_LO = 2'h1;
    localparam logic [1:0] BE_HI = 2'h2;
    localparam logic [1:0] BE_WORD = 2'h3;

    typedef enum logic [2:0] {
        F_RR = 3'h0,
        F_IND = 3'h1,
        F_INC = 3'h2,
        F_IMM3 = 3'h3,
        F_RIMM = 3'h4,
        F_RMEM = 3'h5,
        F_MREG = 3'h6
    } asg_form_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_OPER = 3'h1,
        S_MRD = 3'h2,
        S_CALC = 3'h3,
        S_WB = 3'h4,
        S_PINC = 3'h5
    } asg_state_t;

    // field: short forms {dst[7:4], src[3:0]}, long forms direct register address
    typedef struct packed {
        logic sub_op;
        logic carry_op;
        logic byte_op;
        asg_form_t form;
        logic spare;
        logic lane;
        logic [7:0] field;
        logic [15:0] ext;
    } asg_instr_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
        logic [1:0] be;
    } asg_rf_wr_t;

    typedef struct packed {
        logic we;
        logic byte_op;
        logic [15:0] addr;
        logic [15:0] wdata;
    } asg_mem_t;

    typedef struct packed {
        logic z;
        logic n;
        logic v;
        logic c;
    } asg_flags_t;
endpackage
